// file: logic/pfme_cv_store.sv
module pfme_cv_store
(
   // Clock and reset
   input  wire logic   mclk,
   input  wire logic   arst_n,
   // Shared store port
   pfme_store_if.store bus
);
   import pfme_pkg::*;

   typedef struct packed
   {
      logic [FLAT_CVS-1:0][7:0]                flat;
      logic [NUM_BANKS-1:0][BANK_CVS-1:0][7:0] bank;
      logic [7:0]                              rdata;
      logic                                    rvalid;
   } pfme_store_st_t;

   function automatic pfme_store_st_t store_rst();
      pfme_store_st_t v;
      v = '0;
      v.flat[CV_EXT_CFG-1]    = EXT_CFG_RESET;
      v.flat[CV_INDEX_HIGH-1] = INDEX_HIGH_VAL;
      v.flat[CV_INDEX_LOW-1]  = INDEX_LOW_RST;
      return v;
   endfunction : store_rst

   localparam pfme_store_st_t STORE_RST = store_rst();

   pfme_store_st_t    st_r;
   pfme_store_st_t    st_nxt;
   logic [7:0]        idx_high;
   logic [7:0]        idx_low;
   logic              is_banked;
   logic              bank_ok;
   logic [7:0]        flat_i;
   logic [7:0]        bank_off;
   logic [BANK_W-1:0] bank_sel;
   logic [7:0]        rd_val;

   // Bank is taken straight from stored index values, so a new index serves the next access
   assign idx_high  = st_r.flat[CV_INDEX_HIGH-1];
   assign idx_low   = st_r.flat[CV_INDEX_LOW-1];
   assign is_banked = bus.host_cv >= 9'(CV_BANK_FIRST);
   assign bank_ok   = (idx_high == INDEX_HIGH_VAL) && (idx_low < 8'(NUM_BANKS));
   assign flat_i    = 8'(bus.host_cv - 9'h001);
   assign bank_off  = 8'(bus.host_cv - 9'(CV_BANK_FIRST));
   assign bank_sel  = BANK_W'(idx_low);

   // Read mux; CV 0 and unsupported banks read as zero
   always_comb
   begin
      if (bus.host_cv == 9'h000)
         rd_val = 8'h00;
      else if (!is_banked)
         rd_val = st_r.flat[flat_i];
      else if (bank_ok)
         rd_val = st_r.bank[bank_sel][bank_off];
      else
         rd_val = 8'h00;
   end

   // Next state; a read in a write cycle returns the old value
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.rvalid = bus.host_rd;
      if (bus.host_rd)
         st_nxt.rdata = rd_val;
      if (bus.host_wr && bus.host_cv != 9'h000)
      begin
         if (!is_banked)
            st_nxt.flat[flat_i] = bus.host_wdata;
         else if (bank_ok)
            st_nxt.bank[bank_sel][bank_off] = bus.host_wdata;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         st_r <= STORE_RST;
      else
         st_r <= st_nxt;
   end

   // Engine reads its own bank, independent of the host index
   assign bus.eng_data    = st_r.bank[bus.eng_bank][bus.eng_off];
   assign bus.host_rdata  = st_r.rdata;
   assign bus.host_rvalid = st_r.rvalid;
   assign bus.ext_en      = st_r.flat[CV_EXT_CFG-1][EXT_CFG_EN_BIT];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   chk_flat_readback : assert property (
      (bus.host_wr && !is_banked && bus.host_cv != 9'h000) ##1
      (bus.host_rd && !bus.host_wr && $stable(bus.host_cv))
      |=> bus.host_rdata == $past(bus.host_wdata, 2))
      else $error("flat CV read back differs");

   chk_bank_readback : assert property (
      (bus.host_wr && is_banked && bank_ok) ##1
      (bus.host_rd && !bus.host_wr && $stable(bus.host_cv))
      |=> bus.host_rdata == $past(bus.host_wdata, 2))
      else $error("banked CV read back differs");

   chk_ext_enable : assert property (
      (bus.host_wr && bus.host_cv == 9'(CV_EXT_CFG))
      |=> bus.ext_en == $past(bus.host_wdata[EXT_CFG_EN_BIT]))
      else $error("extension enable not taken from config bit");

   cov_bank_write : cover property (bus.host_wr && is_banked && bank_ok);

endmodule : pfme_cv_store

// file: logic/pfme_pkg.sv
package pfme_pkg;

   // Clock and scan pacing
   localparam int unsigned MCLK_HZ        = 50_000_000;
   localparam int unsigned PASS_PERIOD_US = 2000;
   localparam int unsigned PASS_CYCLES    = PASS_PERIOD_US * (MCLK_HZ / 1_000_000);

   // CV numbering and storage shape
   localparam int unsigned CV_NUM_W      = 9;
   localparam int unsigned FLAT_CVS      = 256;
   localparam int unsigned CV_BANK_FIRST = 257;
   localparam int unsigned BANK_CVS      = 255;
   localparam int unsigned NUM_BANKS     = 13;
   localparam int unsigned BANK_W        = 4;

   // Index and configuration CVs
   localparam int unsigned CV_INDEX_HIGH  = 31;
   localparam int unsigned CV_INDEX_LOW   = 32;
   localparam int unsigned CV_EXT_CFG     = 124;
   localparam logic [7:0]  INDEX_HIGH_VAL = 8'h10;
   localparam logic [7:0]  INDEX_LOW_RST  = 8'h00;
   localparam logic [7:0]  EXT_CFG_RESET  = 8'h14;
   localparam int unsigned EXT_CFG_EN_BIT = 3;

   // Mapping table layout
   localparam int unsigned MAP_ROWS       = 72;
   localparam int unsigned CVS_PER_PART   = 10;
   localparam logic [3:0]  COND_BANK_BASE = 4'h3;
   localparam logic [3:0]  ACT_BANK_BASE  = 4'h8;

   // Condition byte: enable, invert, input select
   localparam int unsigned COND_INV_BIT = 7;
   localparam int unsigned COND_EN_BIT  = 6;
   localparam int unsigned COND_SEL_W   = 6;

   // Condition inputs and action targets
   localparam int unsigned NUM_BUTTONS     = 32;
   localparam int unsigned NUM_SENSORS     = 5;
   localparam int unsigned NUM_PHYS        = 22;
   localparam int unsigned NUM_LOGIC       = 24;
   localparam int unsigned NUM_SOUND       = 32;
   localparam int unsigned AUX_FOUR_BIT    = 5;
   localparam int unsigned LOGIC_FIRST_CV  = 3;
   localparam int unsigned SOUND_FIRST_CV  = 6;

   typedef enum logic [1:0]
   {
      PFME_WAIT = 2'b00,
      PFME_COND = 2'b01,
      PFME_ACT  = 2'b10
   } pfme_state_t;

endpackage : pfme_pkg

// file: logic/pfme_store_if.sv
interface pfme_store_if;
   import pfme_pkg::*;

   logic [CV_NUM_W-1:0] host_cv;
   logic                host_wr;
   logic [7:0]          host_wdata;
   logic                host_rd;
   logic [7:0]          host_rdata;
   logic                host_rvalid;
   logic [BANK_W-1:0]   eng_bank;
   logic [7:0]          eng_off;
   logic [7:0]          eng_data;
   logic                ext_en;

   modport store (input host_cv, host_wr, host_wdata, host_rd, eng_bank, eng_off,
                  output host_rdata, host_rvalid, eng_data, ext_en);
   modport engine (output host_cv, host_wr, host_wdata, host_rd, eng_bank, eng_off,
                   input host_rdata, host_rvalid, eng_data, ext_en);
endinterface : pfme_store_if

// file: logic/pfme_top.sv
module pfme_top
#(
   parameter int unsigned PASS_CYCLES_P = pfme_pkg::PASS_CYCLES
)
(
   // Clock and reset
   input  wire logic                             mclk,
   input  wire logic                             arst_n,
   // CV access from the command decoder
   input  wire logic [pfme_pkg::CV_NUM_W-1:0]    cv_num,
   input  wire logic                             cv_wr,
   input  wire logic [7:0]                       cv_wdata,
   input  wire logic                             cv_rd,
   output logic [7:0]                            cv_rdata,
   output logic                                  cv_rvalid,
   // Vehicle state from the command decoder
   input  wire logic [pfme_pkg::NUM_BUTTONS-1:0] fn_buttons,
   input  wire logic                             dir_reverse,
   input  wire logic                             moving,
   // External sensor pins
   input  wire logic [pfme_pkg::NUM_SENSORS-1:0] sensor_pins,
   // Mapped outputs
   output logic [pfme_pkg::NUM_PHYS-1:0]         phys_out,
   output logic                                  front_light,
   output logic                                  rear_light,
   output logic                                  auxiliary_output_four,
   output logic [pfme_pkg::NUM_LOGIC-1:0]        logic_out,
   output logic [pfme_pkg::NUM_SOUND-1:0]        sound_out,
   // Status
   output logic                                  serial_ext_en,
   output logic                                  pass_done
);
   import pfme_pkg::*;

   localparam int unsigned PACE_W = (PASS_CYCLES_P > 1) ? $clog2(PASS_CYCLES_P) : 1;

   typedef struct packed
   {
      logic [NUM_SENSORS-1:0]       sens_m;
      logic [NUM_SENSORS-1:0]       sens_s;
      pfme_state_t                  fsm;
      logic [6:0]                   row;
      logic [3:0]                   idx;
      logic                         row_ok;
      logic [PACE_W-1:0]            pace;
      logic [CVS_PER_PART-1:0][7:0] acc;
      logic [NUM_PHYS-1:0]          phys;
      logic [NUM_LOGIC-1:0]         lgc;
      logic [NUM_SOUND-1:0]         snd;
      logic                         done;
   } pfme_eng_st_t;

   pfme_eng_st_t                 st_r;
   pfme_eng_st_t                 st_nxt;
   logic [CVS_PER_PART-1:0][7:0] acc_n;
   logic [63:0]                  cond_pad;
   logic                         lighting_button;
   logic                         cond_hit;
   logic                         ok_n;
   logic                         pace_wrap;
   logic                         last_cv;
   logic                         last_row;
   logic                         row_end;

   pfme_store_if bus ();

   pfme_cv_store u_store
   (
      .mclk   (mclk),
      .arst_n (arst_n),
      .bus    (bus)
   );

   // Host CV port goes straight into the store
   assign bus.host_cv    = cv_num;
   assign bus.host_wr    = cv_wr;
   assign bus.host_wdata = cv_wdata;
   assign bus.host_rd    = cv_rd;

   // Engine address: bank per row group, 16 CVs per row inside a bank
   assign bus.eng_bank = BANK_W'(((st_r.fsm == PFME_ACT) ? ACT_BANK_BASE : COND_BANK_BASE)
                                 + {1'b0, st_r.row[6:4]});
   assign bus.eng_off  = {st_r.row[3:0], st_r.idx};

   // Condition inputs; unknown selects read as false
   assign lighting_button = fn_buttons[0];
   assign cond_pad = 64'({st_r.sens_s, moving, dir_reverse,
                          fn_buttons[NUM_BUTTONS-1:1], lighting_button});
   assign cond_hit = cond_pad[bus.eng_data[COND_SEL_W-1:0]]
                     ^ bus.eng_data[COND_INV_BIT];

   // Scan position flags
   assign pace_wrap = st_r.pace == PACE_W'(PASS_CYCLES_P - 1);
   assign last_cv   = st_r.idx == 4'(CVS_PER_PART - 1);
   assign last_row  = st_r.row == 7'(MAP_ROWS - 1);

   // Scan engine: one CV per clock, whole pass well inside one pace period
   always_comb
   begin
      st_nxt           = st_r;
      acc_n            = st_r.acc;
      ok_n             = st_r.row_ok;
      row_end          = 1'b0;
      st_nxt.sens_m    = sensor_pins;
      st_nxt.sens_s    = st_r.sens_m;
      st_nxt.done      = 1'b0;
      st_nxt.pace      = pace_wrap ? '0 : PACE_W'(st_r.pace + 1'b1);
      unique case (st_r.fsm)
         PFME_WAIT:
         begin
            // A pass starts only on the pace boundary
            if (pace_wrap)
            begin
               st_nxt.fsm    = PFME_COND;
               st_nxt.row    = 7'h00;
               st_nxt.idx    = 4'h0;
               st_nxt.row_ok = 1'b1;
            end
         end
         PFME_COND:
         begin
            // Disabled condition bytes are don't care, so an empty row is true
            if (bus.eng_data[COND_EN_BIT])
               ok_n = st_r.row_ok & cond_hit;
            if (last_cv)
            begin
               if (ok_n)
               begin
                  st_nxt.fsm = PFME_ACT;
                  st_nxt.idx = 4'h0;
               end
               else
                  row_end = 1'b1;
            end
            else
            begin
               st_nxt.idx    = 4'(st_r.idx + 4'h1);
               st_nxt.row_ok = ok_n;
            end
         end
         PFME_ACT:
         begin
            // Actions OR together so outputs may have many sources
            acc_n[st_r.idx] = st_r.acc[st_r.idx] | bus.eng_data;
            st_nxt.acc      = acc_n;
            if (last_cv)
               row_end = 1'b1;
            else
               st_nxt.idx = 4'(st_r.idx + 4'h1);
         end
         default:
         begin
            st_nxt.fsm = PFME_WAIT;
         end
      endcase
      if (row_end)
      begin
         if (last_row)
         begin
            // Outputs change only once per pass, so no row order glitches
            st_nxt.phys = NUM_PHYS'(acc_n[LOGIC_FIRST_CV-1:0]);
            st_nxt.lgc  = NUM_LOGIC'(acc_n[SOUND_FIRST_CV-1:LOGIC_FIRST_CV]);
            st_nxt.snd  = NUM_SOUND'(acc_n[CVS_PER_PART-1:SOUND_FIRST_CV]);
            st_nxt.acc  = '0;
            st_nxt.done = 1'b1;
            st_nxt.fsm  = PFME_WAIT;
         end
         else
         begin
            st_nxt.row    = 7'(st_r.row + 7'h01);
            st_nxt.idx    = 4'h0;
            st_nxt.row_ok = 1'b1;
            st_nxt.fsm    = PFME_COND;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // Outputs straight from state
   assign phys_out              = st_r.phys;
   assign front_light           = st_r.phys[0];
   assign rear_light            = st_r.phys[1];
   assign auxiliary_output_four = st_r.phys[AUX_FOUR_BIT];
   assign logic_out             = st_r.lgc;
   assign sound_out             = st_r.snd;
   assign pass_done             = st_r.done;
   assign serial_ext_en         = bus.ext_en;
   assign cv_rdata              = bus.host_rdata;
   assign cv_rvalid             = bus.host_rvalid;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   chk_row_bound : assert property (
      st_r.row <= 7'(MAP_ROWS - 1))
      else $error("row index past table end");

   chk_pass_wrap : assert property (
      st_r.done |-> $past(st_r.row) == 7'(MAP_ROWS - 1) && st_r.fsm == PFME_WAIT)
      else $error("pass ended on wrong row");

   chk_row_step : assert property (
      (row_end && !last_row) |=> st_r.row == 7'($past(st_r.row) + 7'h01)
                                 && st_r.idx == 4'h0 && st_r.fsm == PFME_COND)
      else $error("row did not advance by one");

   chk_pass_start : assert property (
      (st_r.fsm == PFME_WAIT && pace_wrap) |=> st_r.fsm == PFME_COND && st_r.row == 7'h00)
      else $error("pass did not start at first row");

   chk_act_gate : assert property (
      (st_r.fsm == PFME_COND && last_cv) |=> (st_r.fsm == PFME_ACT) == $past(ok_n))
      else $error("actions taken without all conditions");

   // A failing last row still clears the collected actions for the next pass
   chk_fail_skip : assert property (
      (st_r.fsm == PFME_COND && last_cv && !ok_n)
      |=> $stable(st_r.acc) || ($past(last_row) && st_r.acc == '0))
      else $error("failed row changed actions");

   chk_cond_bank : assert property (
      st_r.fsm == PFME_COND |-> bus.eng_bank == BANK_W'(COND_BANK_BASE + {1'b0, st_r.row[6:4]}))
      else $error("condition read from wrong bank");

   chk_act_bank : assert property (
      st_r.fsm == PFME_ACT |-> bus.eng_bank == BANK_W'(ACT_BANK_BASE + {1'b0, st_r.row[6:4]}))
      else $error("action read from wrong bank");

   chk_out_hold : assert property (
      !st_r.done |-> $stable(st_r.phys) && $stable(st_r.snd))
      else $error("outputs changed outside pass end");

   // Scan position stays inside the row and the pace period
   chk_idx_bound : assert property (
      st_r.idx <= 4'(CVS_PER_PART - 1))
      else $error("CV index past row end");

   chk_pace_bound : assert property (
      st_r.pace <= PACE_W'(PASS_CYCLES_P - 1))
      else $error("pace counter past its period");

   chk_wait_hold : assert property (
      (st_r.fsm == PFME_WAIT && !pace_wrap) |=> st_r.fsm == PFME_WAIT)
      else $error("pass started off the pace boundary");

   // Pass end is a single pulse and leaves a clean accumulator
   chk_done_pulse : assert property (
      st_r.done |=> !st_r.done)
      else $error("pass done longer than one cycle");

   chk_acc_clear : assert property (
      st_r.done |-> st_r.acc == '0)
      else $error("actions carried into next pass");

   // Condition AND: one failed enabled byte clears the row, disabled bytes leave it
   chk_cond_and : assert property (
      (st_r.fsm == PFME_COND && !last_cv && bus.eng_data[COND_EN_BIT] && !cond_hit) |=> !st_r.row_ok)
      else $error("failed condition left row true");

   chk_cond_skip : assert property (
      (st_r.fsm == PFME_COND && !last_cv && !bus.eng_data[COND_EN_BIT]) |=> st_r.row_ok == $past(st_r.row_ok))
      else $error("disabled condition changed row");

   chk_row_fresh : assert property (
      (row_end && !last_row) |=> st_r.row_ok)
      else $error("new row did not start true");

   // Actions only ever add bits inside a pass, so several rows may share an output
   chk_act_grow : assert property (
      (st_r.fsm == PFME_ACT && !last_row) |=> (st_r.acc & $past(st_r.acc)) == $past(st_r.acc))
      else $error("action dropped an earlier source");

   cov_pass_end : cover property (st_r.done);
   cov_row_acts : cover property (st_r.fsm == PFME_COND && last_cv && ok_n);
   cov_aux_four : cover property ($rose(auxiliary_output_four));
   cov_ext_on   : cover property ($rose(serial_ext_en));

endmodule : pfme_top

// file: sim/paged_function_mapping_engine_test.sv
module paged_function_mapping_engine_test;
   timeunit 1ns;
   timeprecision 100ps;
   import pfme_pkg::*;

   localparam int PASS_P = 2000;

   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic [8:0]  cv_num;
   logic        cv_wr;
   logic [7:0]  cv_wdata;
   logic        cv_rd;
   logic [7:0]  cv_rdata;
   logic        cv_rvalid;
   logic [31:0] fn_buttons;
   logic        dir_reverse;
   logic        moving;
   logic [4:0]  sensor_pins;
   logic [21:0] phys_out;
   logic        front_light;
   logic        rear_light;
   logic        auxiliary_output_four;
   logic [23:0] logic_out;
   logic [31:0] sound_out;
   logic        serial_ext_en;
   logic        pass_done;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;

   // Block under test, pace shortened so a pass fits a short run
   pfme_top #(.PASS_CYCLES_P(PASS_P)) u_pfme_top
   (
      .mclk(mclk), .arst_n(arst_n), .cv_num(cv_num), .cv_wr(cv_wr), .cv_wdata(cv_wdata),
      .cv_rd(cv_rd), .cv_rdata(cv_rdata), .cv_rvalid(cv_rvalid), .fn_buttons(fn_buttons),
      .dir_reverse(dir_reverse), .moving(moving), .sensor_pins(sensor_pins), .phys_out(phys_out),
      .front_light(front_light), .rear_light(rear_light), .auxiliary_output_four(auxiliary_output_four),
      .logic_out(logic_out), .sound_out(sound_out), .serial_ext_en(serial_ext_en), .pass_done(pass_done)
   );

   // Programmer on the far side of the CV port
   pfme_station u_pfme_station
   (
      .mclk(mclk), .cv_num(cv_num), .cv_wr(cv_wr), .cv_wdata(cv_wdata),
      .cv_rd(cv_rd), .cv_rdata(cv_rdata), .cv_rvalid(cv_rvalid)
   );

   // 50 MHz clock
   always #10 mclk = ~mclk;

   // Hang guard, well above the expected run length
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_mismatch++;
         $display("ERROR t=%0t timeout cyc=%h limit=%h", $time, cyc, 60000);
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   // Two pulses, so the later pass saw the inputs set before it began
   task automatic wait_pass;
      int k;
      int seen;
      seen = 0;
      for (k = 0; k < 3 * PASS_P && seen < 2; k++)
      begin
         @(posedge mclk);
         #1;
         if (pass_done === 1'b1)
            seen++;
      end
      check(seen, 2);
   endtask : wait_pass

   task automatic test_reset;
      logic [7:0] d;
      u_pfme_station.rd(9'h01F, d);
      check(d, 8'h10);
      u_pfme_station.rd(9'h020, d);
      check(d, 8'h00);
      u_pfme_station.rd(9'h07C, d);
      check(d, 8'h14);
      check(serial_ext_en, 1'b0);
      check(phys_out, 22'h0);
      $display("test reset done");
   endtask : test_reset

   task automatic test_bank;
      logic [7:0] d;
      u_pfme_station.set_bank(8'h00);
      u_pfme_station.wr(9'h12C, 8'hA5);
      u_pfme_station.set_bank(8'h01);
      u_pfme_station.wr(9'h12C, 8'h5A);
      u_pfme_station.rd(9'h12C, d); // Read straight after the banked write
      check(d, 8'h5A);
      u_pfme_station.wr(9'h064, 8'h3C);
      u_pfme_station.set_bank(8'h00);
      u_pfme_station.rd(9'h12C, d); // Read right after the index write
      check(d, 8'hA5);
      u_pfme_station.rd(9'h064, d);
      check(d, 8'h3C);
      u_pfme_station.wr(9'h01F, 8'h11);
      u_pfme_station.rd(9'h12C, d);
      check(d, 8'h00);
      u_pfme_station.rd(9'h064, d);
      check(d, 8'h3C);
      $display("test bank done");
   endtask : test_bank

   task automatic test_ext;
      logic [7:0] d;
      u_pfme_station.wr(9'h07C, 8'h1C);
      u_pfme_station.rd(9'h07C, d);
      check(d, 8'h1C);
      check(serial_ext_en, 1'b1);
      $display("test ext done");
   endtask : test_ext

   task automatic test_pace;
      int k;
      int gap;
      gap = 0;
      for (k = 0; k < 3 * PASS_P && pass_done !== 1'b1; k++)
      begin
         @(posedge mclk);
         #1;
      end
      for (k = 0; k < 3 * PASS_P && gap == 0; k++)
      begin
         @(posedge mclk);
         #1;
         if (pass_done === 1'b1)
            gap = k + 1;
      end
      check(gap, PASS_P);
      $display("test pace done");
   endtask : test_pace

   // Rows 5..10 get conditions; rows 1..4 carry the constant aux four action, row 72 a constant sound action
   task automatic test_map;
      logic [31:0] btn [4] = '{32'h0, 32'h29, 32'h108, 32'h100};
      logic [3:0]  rev = 4'b0100;
      logic [3:0]  mov = 4'b0110;
      logic [3:0]  sen = 4'b1000;
      logic [21:0] ep;
      logic        both;
      logic        no_f8;
      int          i;
      u_pfme_station.set_bank(8'h03);
      u_pfme_station.wr(9'h141, 8'h43);
      u_pfme_station.wr(9'h142, 8'h45);
      u_pfme_station.wr(9'h151, 8'hC8);
      u_pfme_station.wr(9'h161, 8'h60);
      u_pfme_station.wr(9'h171, 8'h62);
      u_pfme_station.wr(9'h181, 8'h40);
      u_pfme_station.wr(9'h191, 8'h61);
      u_pfme_station.set_bank(8'h08);
      u_pfme_station.wr(9'h101, 8'h30);
      u_pfme_station.wr(9'h111, 8'h30);
      u_pfme_station.wr(9'h121, 8'h30);
      u_pfme_station.wr(9'h131, 8'h30);
      u_pfme_station.wr(9'h141, 8'h04);
      u_pfme_station.wr(9'h147, 8'h01);
      u_pfme_station.wr(9'h151, 8'h02);
      u_pfme_station.wr(9'h152, 8'h01);
      u_pfme_station.wr(9'h162, 8'h01);
      u_pfme_station.wr(9'h164, 8'h01);
      u_pfme_station.wr(9'h177, 8'h80);
      u_pfme_station.wr(9'h181, 8'h01);
      u_pfme_station.wr(9'h193, 8'h01);
      u_pfme_station.set_bank(8'h0C);
      u_pfme_station.wr(9'h17A, 8'h80);
      u_pfme_station.idle();
      // Each case sets inputs, lets two passes run, then judges every mapped output
      for (i = 0; i < 4; i++)
      begin
         fn_buttons  = btn[i];
         dir_reverse = rev[i];
         moving      = mov[i];
         sensor_pins = {4'h0, sen[i]};
         wait_pass();
         both  = btn[i][3] & btn[i][5];
         no_f8 = ~btn[i][8];
         ep    = 22'h30 | (22'(both) << 2) | (22'(no_f8) << 1) | (22'(no_f8 | rev[i]) << 8)
                 | (22'(mov[i]) << 16) | 22'(btn[i][0]);
         check(phys_out, ep);
         check(rear_light, no_f8);
         check(auxiliary_output_four, 1'b1);
         check(front_light, btn[i][0]);
         check(logic_out, 24'(rev[i]));
         check(sound_out, 32'h80000000 | 32'(both) | (32'(sen[i]) << 7));
      end
      $display("test map done");
   endtask : test_map

   // Main sequence
   initial
   begin
      fn_buttons  = '0;
      dir_reverse = 1'b0;
      moving      = 1'b0;
      sensor_pins = '0;
      repeat (8) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      test_reset();
      test_bank();
      test_ext();
      test_pace();
      test_map();
      print_verdict();
   end
endmodule : paged_function_mapping_engine_test

// file: sim/pfme_station.sv
module pfme_station
(
   // Clock
   input  wire logic                          mclk,
   // CV requests toward the block
   output logic [pfme_pkg::CV_NUM_W-1:0]      cv_num,
   output logic                               cv_wr,
   output logic [7:0]                         cv_wdata,
   output logic                               cv_rd,
   // Read answer from the block
   input  wire logic [7:0]                    cv_rdata,
   input  wire logic                          cv_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   import pfme_pkg::*;

   // Quiet port at time zero
   initial
   begin
      cv_num   = '0;
      cv_wr    = 1'b0;
      cv_wdata = 8'h00;
      cv_rd    = 1'b0;
   end

   // One write per cycle; strobe stays up so writes can run back to back
   task automatic wr(input logic [8:0] n, input logic [7:0] d);
      cv_rd    = 1'b0;
      cv_num   = n;
      cv_wdata = d;
      cv_wr    = 1'b1;
      @(posedge mclk);
      #1;
   endtask : wr

   // Lower the strobe after a burst of writes
   task automatic idle;
      cv_wr    = 1'b0;
      cv_wdata = ~cv_wdata;
      @(posedge mclk);
      #1;
   endtask : idle

   // Read waits a bounded time; released lines show the inverse, never stale data
   task automatic rd(input logic [8:0] n, output logic [7:0] d);
      int k;
      d        = 8'hXX;
      cv_wr    = 1'b0;
      cv_wdata = ~cv_wdata;
      cv_num   = n;
      cv_rd    = 1'b1;
      @(posedge mclk);
      #1;
      cv_rd  = 1'b0;
      cv_num = ~n;
      for (k = 0; k < 3; k++)
      begin
         if (cv_rvalid === 1'b1)
            d = cv_rdata;
         @(posedge mclk);
         #1;
      end
   endtask : rd

   // Index BANK_INDEX_HIGH always 16, BANK_INDEX_LOW set before any banked write
   task automatic set_bank(input logic [7:0] b);
      wr(9'h01F, 8'h10);
      wr(9'h020, b);
   endtask : set_bank
endmodule : pfme_station
